// *** hdl/plcc_pkg.sv ***
// Function
// - Max link speed always reads 2.5 Gb/s code
// - Max width read-only, from strap, default x1
// - ASPM support read-only, resets to 01b
// - ASPM support, exit latency and port defaults overridable by SMBus/EEPROM load
// - L0s exit latency resets to 011b
// - L1 exit latency resets to 000b
// - Surprise-down capable on downstream, zero upstream
// - DL-active capable: zero upstream, one hot-plug downstream
// - Port number defaults to port index, overridable
// - ASPM control two bits, resets disabled
// - Receiver may enter L0s regardless
// - Read completion boundary reads zero
// - Link disable downstream only, tied upstream
// - Retrain pulse downstream, always reads zero
// - Extended synch selects 4096 FTS, 1024 TS1
// - Training flag set while training, hardware clears
package plcc_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] PLCC_OFS_CAP      = 8'hEC;
	localparam logic [7:0] PLCC_OFS_CTL      = 8'hF0;
	// Status word of this block
	localparam logic [7:0] PLCC_OFS_STAT     = 8'hF8;
	// Highest port index a device carries
	localparam logic [7:0] PLCC_PORT_MAX     = 8'h02;
	// Override load port addresses
	localparam logic [1:0] PLCC_LD_ASPM      = 2'h0;
	localparam logic [1:0] PLCC_LD_L0S       = 2'h1;
	localparam logic [1:0] PLCC_LD_L1        = 2'h2;
	localparam logic [1:0] PLCC_LD_PORT      = 2'h3;
	// ==========================================
	// Field positions
	localparam int PLCC_CAP_SPD_LSB  = 0;
	localparam int PLCC_CAP_WID_LSB  = 4;
	localparam int PLCC_CAP_ASPM_LSB = 10;
	localparam int PLCC_CAP_L0S_LSB  = 12;
	localparam int PLCC_CAP_L1_LSB   = 15;
	localparam int PLCC_CAP_SDE_BIT  = 19;
	localparam int PLCC_CAP_DLA_BIT  = 20;
	localparam int PLCC_CAP_PORT_LSB = 24;
	localparam int PLCC_CTL_DIS_BIT  = 4;
	localparam int PLCC_CTL_RTR_BIT  = 5;
	localparam int PLCC_CTL_CCK_BIT  = 6;
	localparam int PLCC_CTL_XSY_BIT  = 7;
	// ==========================================
	// Reset values and fixed codes
	localparam logic [3:0] PLCC_SPD_2G5      = 4'h1;
	localparam logic [5:0] PLCC_WID_X1       = 6'h01;
	localparam logic [1:0] PLCC_ASPM_RST     = 2'h1;
	localparam logic [2:0] PLCC_L0S_RST      = 3'h3;
	localparam logic [2:0] PLCC_L1_RST       = 3'h0;
	// ==========================================
	// Ordered-set counts for extended synch
	localparam logic [12:0] PLCC_FTS_EXT     = 13'h1000;
	localparam logic [12:0] PLCC_TS1_EXT     = 13'h0400;
	// ==========================================
	// ASPM control encodings
	typedef enum logic [1:0] {
		PLCC_ASPM_OFF,
		PLCC_ASPM_L0S,
		PLCC_ASPM_L1,
		PLCC_ASPM_BOTH
	} plcc_aspm_t;
	// Link control outputs
	typedef struct packed {
		logic [1:0] aspm_ctl;
		logic       link_dis;
		logic       retrain;
		logic       common_clk;
		logic       ext_synch;
	} plcc_ctl_t;
	// Override load request
	typedef struct packed {
		logic       valid;
		logic [1:0] sel;
		logic [7:0] data;
	} plcc_load_t;
endpackage

// *** hdl/plcc_sync.sv ***
`timescale 1ns/1ps
module plcc_sync #(
	parameter int W = 1
) (
	// Clock
	input  wire logic         mclk,
	// Data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_q; // First stage, read by second only
	// ==========================================
	// Elaboration check
	if (W < 1) begin : g_bad_width
		$error("synchroniser width below one");
	end
	// ==========================================
	// Two-flop synchroniser, no reset so a held pin flows through reset
	always_ff @(posedge mclk) begin
		s1_q <= din;
		dout <= s1_q;
	end
endmodule // plcc_sync

// *** hdl/plcc_train.sv ***
`timescale 1ns/1ps
module plcc_train (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Training logic
	input  wire logic train_start,
	input  wire logic train_done,
	// Flag
	output logic      training_q
);
	// ==========================================
	// Training flag: set wins over clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			training_q <= 1'b0;
		end else if (train_start) begin
			training_q <= 1'b1;
		end else if (train_done) begin
			training_q <= 1'b0;
		end
	end

	// ==========================================
	// Checks
	property p_train_clear;
		@(posedge mclk) disable iff (rst)
		(train_done && !train_start) |=> !training_q;
	endproperty
	a_train_clear: assert property (p_train_clear) else $error("flag not cleared");
endmodule // plcc_train

// *** hdl/plcc_regs.sv ***
`timescale 1ns/1ps
module plcc_regs #(
	parameter logic [7:0] PORT_INDEX = 8'h00, // Default port number
	parameter bit         DOWNSTREAM = 1'b0,  // Downstream port
	parameter bit         HOTPLUG    = 1'b0,  // Hot-plug capable
	parameter bit         SURPRISE   = 1'b0   // Surprise-down detection
) (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst,
	// Register port
	input  wire logic [7:0]           addr,
	input  wire logic [31:0]          wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output logic      [31:0]          rdata,
	// Width strap pins
	input  wire logic [5:0]           width_strap,
	// SMBus or EEPROM override load
	input  wire plcc_pkg::plcc_load_t load,
	// Training logic
	input  wire logic                 train_done,
	// Link control to physical layer
	output plcc_pkg::plcc_ctl_t       ctl,
	output logic      [12:0]          fts_count,
	output logic      [12:0]          ts1_count,
	output logic                      rx_l0s_allow,
	output logic                      training
);
	// ==========================================
	// Elaboration checks: refuse settings the logic cannot serve
	// Data-link-active reporting is only defined downstream
	if (HOTPLUG && !DOWNSTREAM) begin : g_bad_hotplug
		$error("hot-plug needs downstream");
	end
	// Only three ports exist, numbered from zero
	if (PORT_INDEX > plcc_pkg::PLCC_PORT_MAX) begin : g_bad_index
		$error("port index out of range");
	end

	// ==========================================
	// Declarations
	logic [5:0]  width_s;     // Synchronised strap
	logic [5:0]  width_q;     // Captured width
	logic        cap_done_q;  // Strap captured
	logic [1:0]  aspm_sup_q;  // ASPM support
	logic [2:0]  l0s_lat_q;   // L0s exit latency
	logic [2:0]  l1_lat_q;    // L1 exit latency
	logic [7:0]  port_q;      // Port number
	logic [1:0]  aspm_q;      // ASPM control
	logic        dis_q;       // Link disable
	logic        cck_q;       // Common clock
	logic        xsy_q;       // Extended synch
	logic        rtr_pulse;   // Retrain write
	logic        wr_ctl;      // Control write
	logic [31:0] cap_word;    // Assembled capability
	logic [15:0] ctl_word;    // Assembled control

	// Strap synchroniser, free running so the strap is settled at release
	plcc_sync #(.W(6)) u_sync (
		.mclk (mclk),
		.din  (width_strap),
		.dout (width_s)
	);

	// ==========================================
	// Strap capture after reset release
	// One capture per reset; a strap moved later is not seen
	always_ff @(posedge mclk) begin
		if (rst) begin
			width_q    <= plcc_pkg::PLCC_WID_X1;
			cap_done_q <= 1'b0;
		end else if (!cap_done_q) begin
			width_q    <= (width_s == 6'h00) ? plcc_pkg::PLCC_WID_X1 : width_s;
			cap_done_q <= 1'b1;
		end
	end

	// ==========================================
	// Override load of capability defaults
	// Loads take effect the cycle after the pulse and replace reset defaults
	always_ff @(posedge mclk) begin
		if (rst) begin
			aspm_sup_q <= plcc_pkg::PLCC_ASPM_RST;
			l0s_lat_q  <= plcc_pkg::PLCC_L0S_RST;
			l1_lat_q   <= plcc_pkg::PLCC_L1_RST;
			port_q     <= PORT_INDEX;
		end else if (load.valid) begin
			case (load.sel)
				plcc_pkg::PLCC_LD_ASPM: begin
					aspm_sup_q <= load.data[1:0];
				end
				plcc_pkg::PLCC_LD_L0S: begin
					l0s_lat_q <= load.data[2:0];
				end
				plcc_pkg::PLCC_LD_L1: begin
					l1_lat_q <= load.data[2:0];
				end
				plcc_pkg::PLCC_LD_PORT: begin
					port_q <= load.data;
				end
				default: begin
					// Every select code is decoded above
				end
			endcase
		end
	end

	// ==========================================
	// Control register writes
	assign wr_ctl = wr && (addr == plcc_pkg::PLCC_OFS_CTL);

	// Writable control bits; reserved and read-only bits are dropped
	always_ff @(posedge mclk) begin
		if (rst) begin
			aspm_q <= plcc_pkg::PLCC_ASPM_OFF;
			dis_q  <= 1'b0;
			cck_q  <= 1'b0;
			xsy_q  <= 1'b0;
		end else if (wr_ctl) begin
			aspm_q <= wdata[1:0];
			dis_q  <= DOWNSTREAM & wdata[plcc_pkg::PLCC_CTL_DIS_BIT];
			cck_q  <= wdata[plcc_pkg::PLCC_CTL_CCK_BIT];
			xsy_q  <= wdata[plcc_pkg::PLCC_CTL_XSY_BIT];
		end
	end

	// Retrain is a write-only pulse
	// Never stored, so control reads always show it as zero
	assign rtr_pulse = wr_ctl & DOWNSTREAM & wdata[plcc_pkg::PLCC_CTL_RTR_BIT];

	// Training flag keeper
	plcc_train u_train (
		.mclk        (mclk),
		.rst         (rst),
		.train_start (rtr_pulse),
		.train_done  (train_done),
		.training_q  (training)
	);

	// ==========================================
	// Word assembly, reserved bits zero
	// Whole words start at zero so reserved positions read zero
	always_comb begin
		cap_word = 32'h0000_0000;
		cap_word[plcc_pkg::PLCC_CAP_SPD_LSB +: 4]  = plcc_pkg::PLCC_SPD_2G5;
		cap_word[plcc_pkg::PLCC_CAP_WID_LSB +: 6]  = width_q;
		cap_word[plcc_pkg::PLCC_CAP_ASPM_LSB +: 2] = aspm_sup_q;
		cap_word[plcc_pkg::PLCC_CAP_L0S_LSB +: 3]  = l0s_lat_q;
		cap_word[plcc_pkg::PLCC_CAP_L1_LSB +: 3]   = l1_lat_q;
		cap_word[plcc_pkg::PLCC_CAP_SDE_BIT]       = DOWNSTREAM & SURPRISE;
		cap_word[plcc_pkg::PLCC_CAP_DLA_BIT]       = DOWNSTREAM & HOTPLUG;
		cap_word[plcc_pkg::PLCC_CAP_PORT_LSB +: 8] = port_q;
		ctl_word = 16'h0000;
		ctl_word[1:0] = aspm_q;
		ctl_word[plcc_pkg::PLCC_CTL_DIS_BIT] = dis_q;
		ctl_word[plcc_pkg::PLCC_CTL_CCK_BIT] = cck_q;
		ctl_word[plcc_pkg::PLCC_CTL_XSY_BIT] = xsy_q;
	end

	// ==========================================
	// Read data, one cycle after strobe
	// Zero outside the answer cycle so a stale word is never seen
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			case (addr)
				plcc_pkg::PLCC_OFS_CAP: begin
					rdata <= cap_word;
				end
				plcc_pkg::PLCC_OFS_CTL: begin
					rdata <= {16'h0000, ctl_word};
				end
				plcc_pkg::PLCC_OFS_STAT: begin
					rdata <= {31'h0000_0000, training};
				end
				default: begin
					rdata <= 32'h0000_0000;
				end
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// ==========================================
	// Outputs to physical layer
	// Receiver L0s entry stays allowed whatever the control field says
	always_comb begin
		ctl.aspm_ctl   = aspm_q;
		ctl.link_dis   = dis_q;
		ctl.retrain    = rtr_pulse;
		ctl.common_clk = cck_q;
		ctl.ext_synch  = xsy_q;
	end
	assign fts_count    = xsy_q ? plcc_pkg::PLCC_FTS_EXT : 13'h0000;
	assign ts1_count    = xsy_q ? plcc_pkg::PLCC_TS1_EXT : 13'h0000;
	assign rx_l0s_allow = 1'b1;

	// ==========================================
	// Checks
	// Control bits are cleared by reset
	property p_aspm_rst;
		@(posedge mclk) $fell(rst) |-> (aspm_q == 2'h0 && !dis_q && !cck_q && !xsy_q);
	endproperty
	a_aspm_rst: assert property (p_aspm_rst) else $error("control not reset");

	// Speed code is fixed on every capability read
	property p_speed;
		@(posedge mclk) disable iff (rst) rd && addr == plcc_pkg::PLCC_OFS_CAP |=> rdata[3:0] == 4'h1;
	endproperty
	a_speed: assert property (p_speed) else $error("speed code wrong");

	// Retrain, completion boundary and upper bits read zero
	property p_ctl_rd;
		@(posedge mclk) disable iff (rst)
		rd && addr == plcc_pkg::PLCC_OFS_CTL |=> (rdata[5] == 1'b0 && rdata[3] == 1'b0 && rdata[31:8] == 24'h0);
	endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control read bits wrong");

	// Link disable follows the write only downstream
	property p_dis;
		@(posedge mclk) disable iff (rst)
		wr_ctl |=> ctl.link_dis == (DOWNSTREAM & $past(wdata[4]));
	endproperty
	a_dis: assert property (p_dis) else $error("link disable wrong");

	// A retrain request raises the training flag
	property p_rtr;
		@(posedge mclk) disable iff (rst) rtr_pulse |=> training;
	endproperty
	a_rtr: assert property (p_rtr) else $error("retrain not flagged");

	// Extended synch selects the long ordered-set counts
	property p_xsy;
		@(posedge mclk) disable iff (rst) xsy_q |-> (fts_count == 13'h1000 && ts1_count == 13'h0400);
	endproperty
	a_xsy: assert property (p_xsy) else $error("sync counts wrong");

	// Upstream port reports neither optional capability
	property p_sde;
		@(posedge mclk) disable iff (rst) !DOWNSTREAM |-> (cap_word[20:19] == 2'b00);
	endproperty
	a_sde: assert property (p_sde) else $error("upstream caps set");

	// Bus writes never touch the ASPM support and exit latency fields
	property p_ro;
		@(posedge mclk) disable iff (rst || load.valid) wr |=> $stable(cap_word[17:10]);
	endproperty
	a_ro: assert property (p_ro) else $error("read-only changed");

	// ASPM support and exit latency defaults return with reset
	property p_lat_rst;
		@(posedge mclk) $fell(rst) |-> (l0s_lat_q == 3'h3 && l1_lat_q == 3'h0 && aspm_sup_q == 2'h1);
	endproperty
	a_lat_rst: assert property (p_lat_rst) else $error("latency reset wrong");

	// ==========================================
	// Checks on the read path, override loads and port ties
	// Strap or default width never reads as zero lanes
	property p_wid;
		@(posedge mclk) disable iff (rst)
		rd && addr == plcc_pkg::PLCC_OFS_CAP |=> rdata[9:4] != 6'h00;
	endproperty
	a_wid: assert property (p_wid) else $error("width field zero");

	// Reserved capability positions read zero
	property p_rsvd_cap;
		@(posedge mclk) disable iff (rst)
		rd && addr == plcc_pkg::PLCC_OFS_CAP |=> (rdata[18] == 1'b0 && rdata[23:21] == 3'h0);
	endproperty
	a_rsvd_cap: assert property (p_rsvd_cap) else $error("reserved capability bits set");

	// Status word carries only the training flag
	property p_stat;
		@(posedge mclk) disable iff (rst)
		rd && addr == plcc_pkg::PLCC_OFS_STAT |=> rdata[31:1] == 31'h0000_0000;
	endproperty
	a_stat: assert property (p_stat) else $error("status upper bits set");

	// Upstream port can neither disable nor retrain
	property p_up_tie;
		@(posedge mclk) disable iff (rst)
		!DOWNSTREAM |-> (!ctl.link_dis && !ctl.retrain && !training);
	endproperty
	a_up_tie: assert property (p_up_tie) else $error("upstream link control active");

	// ASPM support load lands the next cycle
	property p_aspm_ld;
		@(posedge mclk) disable iff (rst)
		load.valid && load.sel == plcc_pkg::PLCC_LD_ASPM |=> aspm_sup_q == $past(load.data[1:0]);
	endproperty
	a_aspm_ld: assert property (p_aspm_ld) else $error("support load lost");

	// Port number load lands the next cycle
	property p_port_ld;
		@(posedge mclk) disable iff (rst)
		load.valid && load.sel == plcc_pkg::PLCC_LD_PORT |=> port_q == $past(load.data);
	endproperty
	a_port_ld: assert property (p_port_ld) else $error("port number load lost");

	// Without extended synch no long counts are requested
	property p_xsy_off;
		@(posedge mclk) disable iff (rst)
		!xsy_q |-> (fts_count == 13'h0000 && ts1_count == 13'h0000);
	endproperty
	a_xsy_off: assert property (p_xsy_off) else $error("sync counts not cleared");

	// Receiver L0s stays allowed with L0s entry disabled
	property p_l0s;
		@(posedge mclk) disable iff (rst)
		aspm_q[0] == 1'b0 |-> rx_l0s_allow;
	endproperty
	a_l0s: assert property (p_l0s) else $error("receiver L0s blocked");
endmodule // plcc_regs

// *** testbench/plcc_train_partner.sv ***
`timescale 1ns/1ps
// ==========================================
// Training logic model: answers a retrain request after a delay
module plcc_train_partner #(
	parameter int DELAY = 20 // Cycles from request to completion
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Training request and completion
	input  wire logic start,
	output logic      done_q
);
	int cnt_q; // Cycles left until completion

	// Count down, pulse completion once when the count expires
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q  <= 0;
			done_q <= 1'b0;
		end else begin
			done_q <= (cnt_q == 1);
			if (start) begin
				cnt_q <= DELAY;
			end else if (cnt_q != 0) begin
				cnt_q <= cnt_q - 1;
			end
		end
	end
endmodule // plcc_train_partner

// *** testbench/plcc_regs_tb_top.sv ***
`timescale 1ns/1ps
// ==========================================
// Bench for the link capability and control registers
module plcc_regs_tb_top;
	// Bench signals
	logic                 mclk, rst, wr, rd, train_done, rx_l0s_allow, training;
	logic [7:0]           addr;
	logic [31:0]          wdata, rdata;
	logic [5:0]           width_strap;
	logic [12:0]          fts_count, ts1_count;
	plcc_pkg::plcc_load_t load;
	plcc_pkg::plcc_ctl_t  ctl;
	int                   error_cnt, checks_done, n;
	logic [31:0]          rdata_up;
	logic                 training_up;
	plcc_pkg::plcc_ctl_t  ctl_up;

	// Clock at 10 MHz
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Downstream, hot-plug port with index two
	plcc_regs #(.PORT_INDEX(8'h02), .DOWNSTREAM(1'b1), .HOTPLUG(1'b1), .SURPRISE(1'b1)) uut (
		.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.width_strap(width_strap), .load(load), .train_done(train_done), .ctl(ctl),
		.fts_count(fts_count), .ts1_count(ts1_count), .rx_l0s_allow(rx_l0s_allow), .training(training));

	// Far-side training logic
	plcc_train_partner #(.DELAY(20)) partner (.mclk(mclk), .rst(rst), .start(ctl.retrain), .done_q(train_done));

	// Upstream port with index zero on the same bus and strap
	plcc_regs #(.PORT_INDEX(8'h00), .DOWNSTREAM(1'b0), .HOTPLUG(1'b0), .SURPRISE(1'b1)) uut_up (
		.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_up),
		.width_strap(width_strap), .load(load), .train_done(train_done), .ctl(ctl_up),
		.fts_count(), .ts1_count(), .rx_l0s_allow(), .training(training_up));

	// ==========================================
	// Compare, count, report
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One-cycle register write
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		#1;
	endtask

	// One-cycle read, data checked in the following cycle
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	// One-cycle override load pulse
	task ld(input logic [1:0] s, input logic [7:0] d);
		@(posedge mclk);
		load <= '{valid: 1'b1, sel: s, data: d};
		@(posedge mclk);
		load <= '0;
	endtask

	// Verdict and end of run
	task final_report;
		$display("Errors %0d, checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		error_cnt   = 0;
		checks_done = 0;
		rst         = 1'b1;
		wr          = 1'b0;
		rd          = 1'b0;
		addr        = 8'h00;
		wdata       = 32'h0000_0000;
		width_strap = 6'h04;
		load        = '0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		// Reset values, strap width x4
		rd_chk(plcc_pkg::PLCC_OFS_CAP, 32'h0218_3441);
		chk(rdata_up, 32'h0000_3441);
		rd_chk(plcc_pkg::PLCC_OFS_CTL, 32'h0000_0000);
		chk({31'h0, rx_l0s_allow}, 32'h0000_0001);
		// Read-only word ignores writes
		wr_reg(plcc_pkg::PLCC_OFS_CAP, 32'hFFFF_FFFF);
		rd_chk(plcc_pkg::PLCC_OFS_CAP, 32'h0218_3441);
		// All ones to control: disable, retrain, common clock, extended synch
		wr_reg(plcc_pkg::PLCC_OFS_CTL, 32'hFFFF_FFFF);
		rd_chk(plcc_pkg::PLCC_OFS_STAT, 32'h0000_0001);
		chk(rdata_up, 32'h0000_0000);
		chk({26'h0, ctl}, 32'h0000_003B);
		chk({26'h0, ctl_up}, 32'h0000_0033);
		chk({19'h0, fts_count}, 32'h0000_1000);
		chk({19'h0, ts1_count}, 32'h0000_0400);
		rd_chk(plcc_pkg::PLCC_OFS_CTL, 32'h0000_00D3);
		chk(rdata_up, 32'h0000_00C3);
		// Bounded wait for training to finish
		for (n = 0; n < 100 && training !== 1'b0; n++) begin
			@(posedge mclk);
		end
		if (n == 100) begin
			error_cnt++;
			final_report;
		end
		rd_chk(plcc_pkg::PLCC_OFS_STAT, 32'h0000_0000);
		wr_reg(plcc_pkg::PLCC_OFS_CTL, 32'h0000_0000);
		chk({19'h0, fts_count}, 32'h0000_0000);
		// Every ASPM control code
		for (int i = 0; i < 4; i++) begin
			wr_reg(plcc_pkg::PLCC_OFS_CTL, i);
			rd_chk(plcc_pkg::PLCC_OFS_CTL, i);
			chk({30'h0, ctl.aspm_ctl}, i);
		end
		// Override every loadable field
		ld(plcc_pkg::PLCC_LD_ASPM, 8'h02);
		ld(plcc_pkg::PLCC_LD_L0S, 8'h05);
		ld(plcc_pkg::PLCC_LD_L1, 8'h06);
		ld(plcc_pkg::PLCC_LD_PORT, 8'hA5);
		rd_chk(plcc_pkg::PLCC_OFS_CAP, 32'hA51B_5841);
		// Unmapped address reads zero
		rd_chk(8'h40, 32'h0000_0000);
		// Mid-run reset restores control and capability defaults
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rd_chk(plcc_pkg::PLCC_OFS_CTL, 32'h0000_0000);
		rd_chk(plcc_pkg::PLCC_OFS_CAP, 32'h0218_3441);
		final_report;
	end
endmodule // plcc_regs_tb_top
